//--- core/aci_pkg.sv
// Purpose: shared constants for the converter command interpreter and its host end
// Assumes: byte-level link, one 250 MHz core clock
// Notes: command encodings are value/mask pairs; don't-care bits are masked off
package aci_pkg;
  // clock and conversion timing
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned SPS_20 = 20;
  localparam int unsigned SPS_90 = 90;
  localparam int unsigned SPS_330 = 330;
  localparam int unsigned SPS_1000 = 1000;
  localparam int unsigned CONV_CYC_20 = CLK_HZ / SPS_20;
  localparam int unsigned CONV_CYC_90 = CLK_HZ / SPS_90;
  localparam int unsigned CONV_CYC_330 = CLK_HZ / SPS_330;
  localparam int unsigned CONV_CYC_1000 = CLK_HZ / SPS_1000;
  localparam int unsigned CONV_CNT_W = 24;
  // command bytes
  localparam logic [7:0] CMD_RESET = 8'h06;
  localparam logic [7:0] CMD_RESET_MASK = 8'hfe;
  localparam logic [7:0] CMD_KICK = 8'h08;
  localparam logic [7:0] CMD_KICK_MASK = 8'hfe;
  localparam logic [7:0] CMD_SLEEP = 8'h02;
  localparam logic [7:0] CMD_SLEEP_MASK = 8'hfe;
  localparam logic [7:0] CMD_RESULT_READ = 8'h10;
  localparam logic [7:0] CMD_RESULT_READ_MASK = 8'hf0;
  localparam logic [7:0] CMD_REGISTER_READ = 8'h20;
  localparam logic [7:0] CMD_REGISTER_READ_MASK = 8'hf8;
  localparam int unsigned CMD_REG_SEL_BIT = 2;
  localparam logic [7:0] CMD_CONFIG_WRITE = 8'h40;
  localparam logic [7:0] CMD_CONFIG_WRITE_MASK = 8'hfc;
  // device register map (register index on the link)
  localparam logic REG_CONVERSION_SETUP = 1'b0;
  localparam logic REG_CONVERSION_STATE = 1'b1;
  localparam logic [7:0] SETUP_RESET = 8'h00;
  localparam int unsigned SETUP_MODE_BIT = 1;
  localparam int unsigned SETUP_RATE_LSB = 2;
  localparam int unsigned STATE_READY_BIT = 7;
  // result coding
  localparam int unsigned SAMPLE_W = 26;
  localparam logic [23:0] RESULT_MAX = 24'h7f_ffff;
  localparam logic [23:0] RESULT_MIN = 24'h80_0000;
  localparam int unsigned RESULT_BYTES = 3;
  // host APB map
  localparam logic [7:0] HOST_CTRL_OFS = 8'h00;
  localparam logic [7:0] HOST_STATUS_OFS = 8'h04;
  localparam logic [7:0] HOST_RDATA_OFS = 8'h08;
  localparam int unsigned CTRL_DATA_LSB = 8;
  localparam int unsigned CTRL_COUNT_LSB = 16;
  localparam int unsigned CTRL_READ_BIT = 18;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_READY_BIT = 1;
  localparam int unsigned STAT_FELL_BIT = 2;
endpackage

//--- core/aci_link_if.sv
// Purpose: byte-level link between host end and converter end
// Assumes: bit-level bus engine sits outside; one strobe per latched byte
// Notes: result ready line is open drain, resolved here
`timescale 1ns/1ns
interface aci_link_if;
  logic frame_start;
  logic frame_read;
  logic frame_stop;
  logic wr_valid;
  logic [7:0] wr_byte;
  logic rd_req;
  logic rd_valid;
  logic [7:0] rd_byte;
  logic rdy_out;
  logic rdy_oe;
  logic rdy_line;
  // pull-up wins unless the device pulls low
  assign rdy_line = rdy_oe ? rdy_out : 1'b1;
  modport dev (input frame_start, frame_read, frame_stop, wr_valid, wr_byte, rd_req,
    output rd_valid, rd_byte, rdy_out, rdy_oe);
  modport host (output frame_start, frame_read, frame_stop, wr_valid, wr_byte, rd_req,
    input rd_valid, rd_byte, rdy_line);
endinterface

//--- core/aci_device.sv
// Purpose: converter-side command interpreter, registers and conversion sequencing
// Assumes: each wr_valid marks a byte latched on its eighth falling clock edge
// Notes: analog front end is outside; sample_in is the raw filtered value
`timescale 1ns/1ns
// Functional notes
// RL1 - result saturates at full-scale codes, no wrap
// RL2 - reset, kick, sleep byte encodings
// RL3 - result, register read, config write encodings
// RL4 - act only on latched command bytes
// RL5 - reset restores defaults, link usable immediately
// RL6 - single-shot kick starts or restarts conversion
// RL7 - continuous kick starts, later kicks restart
// RL8 - sleep after current conversion, keep registers; a sleep in a single-shot conversion's last cycle is never taken
// RL9 - kick while asleep restores analog sections
// RL10 - result read loads newest result
// RL11 - completion during command keeps ready low
// RL12 - register read returns selected register
// RL13 - config write stores following data byte
// RL14 - config write clears filter, restarts conversion
// RL15 - ready pin falls on new result
// RL16 - status ready bit shows unread result
// RL17 - host polls at least at conversion rate
// RL18 - new result only loaded on result read
// RL19 - two 8-bit registers, zero reset, kept asleep
// RL20 - status ready bit clears on read-out
// RL21 - truncated config write leaves register unchanged
module aci_device
  import aci_pkg::*;
#(
  parameter int unsigned CYC_20 = CONV_CYC_20,
  parameter int unsigned CYC_90 = CONV_CYC_90,
  parameter int unsigned CYC_330 = CONV_CYC_330,
  parameter int unsigned CYC_1000 = CONV_CYC_1000
)
(
  input wire logic core_clk,
  input wire logic reset_n,
  aci_link_if.dev link,
  input wire logic [SAMPLE_W-1:0] sample_in,
  output logic analog_on,
  output logic filter_clear,
  output logic conv_busy,
  output logic [23:0] latest_result
);

  // counts must fit the conversion counter
  initial
  begin
    if (CYC_20 < 2 || CYC_90 < 2 || CYC_330 < 2 || CYC_1000 < 2 ||
        CYC_20 >= (1 << CONV_CNT_W) || CYC_90 >= (1 << CONV_CNT_W) ||
        CYC_330 >= (1 << CONV_CNT_W) || CYC_1000 >= (1 << CONV_CNT_W))
    begin
      $error("aci_device: conversion counts out of range");
    end
  end

  // saturating conversion of the wide sample to 24-bit two's complement
  function automatic logic [23:0] clip_result(input logic [SAMPLE_W-1:0] s);
    logic signed [SAMPLE_W-1:0] v;
    logic signed [SAMPLE_W-1:0] hi;
    logic signed [SAMPLE_W-1:0] lo;
    v = s;
    hi = SAMPLE_W'(signed'({1'b0, RESULT_MAX}));
    lo = SAMPLE_W'(signed'(RESULT_MIN));
    if (v > hi)
      clip_result = RESULT_MAX;
    else if (v < lo)
      clip_result = RESULT_MIN;
    else
      clip_result = v[23:0];
  endfunction

  // command match against a value/mask pair
  function automatic logic cmd_is(input logic [7:0] b, input logic [7:0] val,
                                  input logic [7:0] mask);
    cmd_is = (b & mask) == val;
  endfunction

  // conversion length for a rate setting, minus one
  function automatic logic [CONV_CNT_W-1:0] conv_last(input logic [1:0] rate);
    case (rate)
      2'd0: conv_last = CONV_CNT_W'(CYC_20 - 1);
      2'd1: conv_last = CONV_CNT_W'(CYC_90 - 1);
      2'd2: conv_last = CONV_CNT_W'(CYC_330 - 1);
      default: conv_last = CONV_CNT_W'(CYC_1000 - 1);
    endcase
  endfunction

  logic [7:0] setup;
  logic ready;
  logic asleep;
  logic sleep_pending;
  logic converting;
  logic [CONV_CNT_W-1:0] conv_cnt;
  logic [23:0] out_shift;
  logic in_write;
  logic first_byte;
  logic wait_data;
  logic conv_done;
  logic cmd_valid;
  logic do_reset;
  logic do_kick;
  logic do_sleep;
  logic do_result;
  logic do_regread;
  logic do_cfgcmd;
  logic do_cfgdata;
  logic [7:0] state_value;

  // decode only on a latched first byte of a write frame
  assign cmd_valid = link.wr_valid && in_write && first_byte && !wait_data; // RL4
  assign do_reset = cmd_valid && cmd_is(link.wr_byte, CMD_RESET, CMD_RESET_MASK); // RL2
  assign do_kick = cmd_valid && cmd_is(link.wr_byte, CMD_KICK, CMD_KICK_MASK); // RL2
  assign do_sleep = cmd_valid && cmd_is(link.wr_byte, CMD_SLEEP, CMD_SLEEP_MASK); // RL2
  assign do_result = cmd_valid &&
    cmd_is(link.wr_byte, CMD_RESULT_READ, CMD_RESULT_READ_MASK); // RL3
  assign do_regread = cmd_valid &&
    cmd_is(link.wr_byte, CMD_REGISTER_READ, CMD_REGISTER_READ_MASK); // RL3
  assign do_cfgcmd = cmd_valid &&
    cmd_is(link.wr_byte, CMD_CONFIG_WRITE, CMD_CONFIG_WRITE_MASK); // RL3
  assign do_cfgdata = link.wr_valid && in_write && wait_data; // RL13
  assign conv_done = converting && conv_cnt == conv_last(setup[SETUP_RATE_LSB +: 2]);
  // reserved status bits read as zero
  assign state_value = {ready, 7'h00};

  // frame tracking: which byte of a write frame is next
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      in_write <= 1'b0;
      first_byte <= 1'b0;
    end
    else if (link.frame_start)
    begin
      in_write <= !link.frame_read;
      first_byte <= 1'b1;
    end
    else if (link.frame_stop)
    begin
      in_write <= 1'b0;
      first_byte <= 1'b0;
    end
    else if (link.wr_valid)
    begin
      first_byte <= 1'b0;
    end
  end

  // config write waits for its data byte; a stop abandons it
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      wait_data <= 1'b0;
    else if (link.frame_stop || link.frame_start || do_cfgdata)
      wait_data <= 1'b0; // RL21
    else if (do_cfgcmd)
      wait_data <= 1'b1;
  end

  // configuration register, kept through sleep
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      setup <= SETUP_RESET; // RL19
    else if (do_reset)
      setup <= SETUP_RESET; // RL5
    else if (do_cfgdata)
      setup <= link.wr_byte; // RL13
  end

  // conversion sequencing; a restart zeroes the counter
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      converting <= 1'b0;
      conv_cnt <= '0;
    end
    else if (do_reset)
    begin
      converting <= 1'b0; // RL5
      conv_cnt <= '0;
    end
    else if (do_kick)
    begin
      converting <= 1'b1; // RL6 RL7 RL9
      conv_cnt <= '0;
    end
    else if (do_cfgdata && converting)
    begin
      conv_cnt <= '0; // RL14
    end
    else if (conv_done)
    begin
      conv_cnt <= '0;
      // continuous mode runs on unless sleep was asked for
      converting <= setup[SETUP_MODE_BIT] && !sleep_pending; // RL7 RL8
    end
    else if (converting)
    begin
      conv_cnt <= conv_cnt + 1'b1;
    end
  end

  // sleep waits for the running conversion; kick wakes
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      asleep <= 1'b0;
      sleep_pending <= 1'b0;
    end
    else if (do_reset || do_kick)
    begin
      asleep <= 1'b0; // RL9
      sleep_pending <= 1'b0;
    end
    else if (do_sleep && !converting)
    begin
      asleep <= 1'b1; // RL8
    end
    else if (do_sleep)
    begin
      sleep_pending <= 1'b1; // RL8
    end
    else if (conv_done && sleep_pending)
    begin
      asleep <= 1'b1; // RL8
      sleep_pending <= 1'b0;
    end
  end

  // newest clipped result
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      latest_result <= 24'h00_0000;
    else if (do_reset)
      latest_result <= 24'h00_0000;
    else if (conv_done)
      latest_result <= clip_result(sample_in); // RL1
  end

  // ready flag: completion beats the clear of a same-cycle read;
  // a reset command beats both, or a late completion would survive it
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      ready <= 1'b0;
    else if (do_reset)
      ready <= 1'b0; // RL5
    else if (conv_done)
      ready <= 1'b1; // RL15 RL16 RL11
    else if (do_result)
      ready <= 1'b0; // RL20
  end

  // output shift register only loads on a read command, shifts on each read request
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      out_shift <= 24'h00_0000;
    else if (do_reset)
      out_shift <= 24'h00_0000;
    else if (do_result)
      out_shift <= latest_result; // RL10 RL18 RL11
    else if (do_regread)
      // register value goes out first, zeros follow
      out_shift <= {(link.wr_byte[CMD_REG_SEL_BIT] == REG_CONVERSION_STATE) ?
                    state_value : setup, 16'h0000}; // RL12
    else if (link.rd_req)
      out_shift <= {out_shift[15:0], 8'h00};
  end

  // read bytes go out one cycle after each request, msb first
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      link.rd_valid <= 1'b0;
      link.rd_byte <= 8'h00;
    end
    else
    begin
      link.rd_valid <= link.rd_req;
      if (link.rd_req)
        link.rd_byte <= out_shift[23:16];
    end
  end

  // open drain: pull low while a result waits
  assign link.rdy_out = 1'b0;
  assign link.rdy_oe = ready; // RL15
  // filter clear on every kick and every config write that gets its data byte
  assign filter_clear = do_kick || do_cfgdata; // RL6 RL14
  assign analog_on = !asleep; // RL8
  assign conv_busy = converting;

endmodule

//--- core/aci_host.sv
// Purpose: host end; APB registers drive frames on the byte link
// Assumes: device answers each read request with rd_valid
// Notes: pready is always high; unmapped reads return zero
`timescale 1ns/1ns
module aci_host
  import aci_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  aci_link_if.host link
);

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_START = 2'b01,
    HS_BYTE = 2'b10,
    HS_STOP = 2'b11
  } aci_hstate_t;

  aci_hstate_t state;
  logic [7:0] cmd_byte;
  logic [7:0] data_byte;
  logic [1:0] count;
  logic [1:0] sent;
  logic is_read;
  logic waiting;
  logic [23:0] rdata;
  logic rdy_s1;
  logic rdy_s2;
  logic rdy_prev;
  logic fell;
  logic wr_ctrl;
  logic wr_status;
  logic rd_status;
  logic fell_evt;

  assign wr_ctrl = psel && penable && pwrite && paddr == HOST_CTRL_OFS && state == HS_IDLE;
  assign wr_status = psel && penable && pwrite && paddr == HOST_STATUS_OFS;
  assign rd_status = psel && penable && !pwrite && paddr == HOST_STATUS_OFS;
  assign fell_evt = rdy_prev && !rdy_s2;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // ready pin crosses in through two flops
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdy_s1 <= 1'b1;
      rdy_s2 <= 1'b1;
      rdy_prev <= 1'b1;
    end
    else
    begin
      rdy_s1 <= link.rdy_line;
      rdy_s2 <= rdy_s1;
      rdy_prev <= rdy_s2;
    end
  end

  // sticky falling-edge flag, a new edge beats the write-one clear
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      fell <= 1'b0;
    else if (fell_evt)
      fell <= 1'b1; // RL15
    else if (wr_status && pwdata[STAT_FELL_BIT])
      fell <= 1'b0;
  end

  // frame sequencer
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= HS_IDLE;
      cmd_byte <= 8'h00;
      data_byte <= 8'h00;
      count <= 2'd0;
      sent <= 2'd0;
      is_read <= 1'b0;
      waiting <= 1'b0;
    end
    else
    begin
      case (state)
        HS_IDLE:
        begin
          if (wr_ctrl && pwdata[CTRL_COUNT_LSB +: 2] != 2'd0)
          begin
            cmd_byte <= pwdata[7:0];
            data_byte <= pwdata[CTRL_DATA_LSB +: 8];
            count <= pwdata[CTRL_COUNT_LSB +: 2];
            is_read <= pwdata[CTRL_READ_BIT];
            sent <= 2'd0;
            state <= HS_START;
          end
        end
        HS_START:
          state <= HS_BYTE;
        HS_BYTE:
        begin
          if (!is_read)
          begin
            // command byte, then optional data byte in the same frame
            sent <= sent + 2'd1; // RL13
            if (sent + 2'd1 == count)
              state <= HS_STOP;
          end
          else if (!waiting)
          begin
            waiting <= 1'b1;
          end
          else if (link.rd_valid)
          begin
            waiting <= 1'b0;
            sent <= sent + 2'd1;
            if (sent + 2'd1 == count)
              state <= HS_STOP;
          end
        end
        HS_STOP:
          state <= HS_IDLE;
        default:
          state <= HS_IDLE;
      endcase
    end
  end

  // collected read bytes, first byte ends up highest
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      rdata <= 24'h00_0000;
    else if (state == HS_START && is_read)
      rdata <= 24'h00_0000;
    else if (link.rd_valid)
      rdata <= {rdata[15:0], link.rd_byte}; // RL10 RL12
  end

  // link strobes are decoded from the sequencer state
  assign link.frame_start = state == HS_START;
  assign link.frame_read = is_read;
  assign link.frame_stop = state == HS_STOP;
  assign link.wr_valid = state == HS_BYTE && !is_read;
  assign link.wr_byte = sent == 2'd0 ? cmd_byte : data_byte;
  assign link.rd_req = state == HS_BYTE && is_read && !waiting;

  // apb read mux; software polls status at conversion rate or faster
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        HOST_STATUS_OFS: prdata <= {29'h0, fell, !rdy_s2, state != HS_IDLE}; // RL17
        HOST_RDATA_OFS: prdata <= {8'h00, rdata};
        HOST_CTRL_OFS: prdata <= {13'h0, is_read, count, data_byte, cmd_byte};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

//--- verif/aci_props.sv
// Purpose: concurrent checks on the byte link between host end and device end
// Assumes: one core clock, asynchronous active-low reset
// Notes: sees link signals only; conversion completions inside the device are invisible
`timescale 1ns/1ns
module aci_props
  import aci_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic frame_start,
  input wire logic frame_read,
  input wire logic frame_stop,
  input wire logic wr_valid,
  input wire logic [7:0] wr_byte,
  input wire logic rd_req,
  input wire logic rd_valid,
  input wire logic [7:0] rd_byte,
  input wire logic rdy_out,
  input wire logic rdy_oe,
  input wire logic rdy_line
);
  logic in_frame;
  logic in_read;
  logic first_pend;
  logic cmd_hit;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  // frame tracking from the start and stop pulses
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      in_frame <= 1'b0;
      in_read <= 1'b0;
    end
    else if (frame_start)
    begin
      in_frame <= 1'b1;
      in_read <= frame_read;
    end
    else if (frame_stop)
      in_frame <= 1'b0;
  end
  // first byte of a write frame is the command, later ones are data
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      first_pend <= 1'b0;
    else if (frame_start)
      first_pend <= !frame_read;
    else if (wr_valid)
      first_pend <= 1'b0;
  end
  // only a result read or a reset command may release the ready line
  assign cmd_hit = wr_valid && first_pend &&
    ((wr_byte & CMD_RESULT_READ_MASK) == CMD_RESULT_READ ||
    (wr_byte & CMD_RESET_MASK) == CMD_RESET);
  chk_no_overlap: assert property (frame_start |-> !in_frame)
    else $error("frame started inside a frame");
  chk_frame_ends: assert property (frame_start |-> ##[1:40] frame_stop)
    else $error("frame not closed in time");
  chk_stop_placed: assert property (frame_stop |-> in_frame)
    else $error("stop outside a frame");
  chk_write_placed: assert property (wr_valid |-> in_frame && !in_read)
    else $error("byte written outside a write frame");
  chk_read_placed: assert property (rd_req |-> in_frame && in_read)
    else $error("byte requested outside a read frame");
  chk_read_answer: assert property (rd_req |=> rd_valid)
    else $error("read request not answered next cycle");
  chk_read_unasked: assert property (!rd_req |=> !rd_valid)
    else $error("read data without request");
  chk_pin_low_only: assert property (rdy_oe |-> !rdy_out)
    else $error("ready pin driven high");
  chk_rise_cause: assert property ($rose(rdy_line) |-> $past(cmd_hit))
    else $error("ready line released without result read");
  cover property (cmd_hit ##1 $rose(rdy_line));
  cover property (rd_req ##1 rd_valid);
  cover property ($fell(rdy_line));
endmodule

//--- verif/adc_command_interpreter_tb.sv
// Purpose: self-checking bench for host and device ends joined by the link
// Assumes: short conversion counts set by parameters
// Notes: read data compared under a mask of the bytes requested
`timescale 1ns/1ns
module adc_command_interpreter_tb
  import aci_pkg::*;
;
  typedef struct packed
  {
    logic [7:0] cmd;
    logic [7:0] data;
    logic [1:0] wcnt;
    logic [1:0] rcnt;
    logic [23:0] exp;
  } aci_row_t;
  logic core_clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [25:0] sample_in;
  logic analog_on, filter_clear, conv_busy;
  logic [23:0] latest_result;
  int fails, check_count, cycles, stops, clears, c0;
  // reg reads, config write with ignored bits, truncated write, trailing zero byte
  aci_row_t rows [6] = '{'{8'h20, 8'h00, 2'h1, 2'h1, 24'h00_0000},
    '{8'h24, 8'h00, 2'h1, 2'h1, 24'h00_0000}, '{8'h43, 8'ha4, 2'h2, 2'h0, 24'h00_0000},
    '{8'h23, 8'h00, 2'h1, 2'h1, 24'h00_00a4}, '{8'h41, 8'h5c, 2'h1, 2'h0, 24'h00_0000},
    '{8'h20, 8'h00, 2'h1, 2'h2, 24'h00_a400}};
  logic [25:0] smp [3] = '{26'h1ff_ffff, 26'h200_0000, 26'h3ff_ffff};
  logic [23:0] cexp [3] = '{24'h7f_ffff, 24'h80_0000, 24'hff_ffff};
  aci_link_if aci_link_if_i ();
  aci_device #(.CYC_20(40), .CYC_90(60), .CYC_330(30), .CYC_1000(20)) aci_device_i (
    .core_clk(core_clk), .reset_n(reset_n), .link(aci_link_if_i.dev), .sample_in(sample_in),
    .analog_on(analog_on), .filter_clear(filter_clear), .conv_busy(conv_busy),
    .latest_result(latest_result));
  aci_host aci_host_i (.core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(aci_link_if_i.host));
  aci_props aci_props_i (.core_clk(core_clk), .reset_n(reset_n),
    .frame_start(aci_link_if_i.frame_start), .frame_read(aci_link_if_i.frame_read),
    .frame_stop(aci_link_if_i.frame_stop), .wr_valid(aci_link_if_i.wr_valid),
    .wr_byte(aci_link_if_i.wr_byte), .rd_req(aci_link_if_i.rd_req),
    .rd_valid(aci_link_if_i.rd_valid), .rd_byte(aci_link_if_i.rd_byte),
    .rdy_out(aci_link_if_i.rdy_out), .rdy_oe(aci_link_if_i.rdy_oe),
    .rdy_line(aci_link_if_i.rdy_line));
  // 250 MHz core clock
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // frame stops and filter clears counted, hang cut short;
  // counts move after the edge so waiting tasks never race them
  always @(posedge core_clk)
  begin
    cycles++;
    if (aci_link_if_i.frame_stop === 1'b1)
      stops <= stops + 1;
    if (filter_clear === 1'b1)
      clears <= clears + 1;
    if (cycles == 20000)
    begin
      fails++;
      test_done();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one apb transfer; idle edge first so psel never toggles twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one link frame, done when the host emits its stop
  task automatic frame(input logic [7:0] cmd, input logic [7:0] data, input logic [1:0] cnt,
    input logic rd);
    int s0;
    s0 = stops;
    apb(1'b1, HOST_CTRL_OFS, {13'h0, rd, cnt, data, cmd});
    while (stops == s0)
      @(posedge core_clk);
  endtask
  task automatic rdchk(input string name, input logic [1:0] cnt, input logic [23:0] exp);
    logic [31:0] m;
    m = (32'h1 << (8 * cnt)) - 32'h1;
    frame(8'h00, 8'h00, cnt, 1'b1);
    apb(1'b0, HOST_RDATA_OFS, 32'h0);
    check(name, q & m, {8'h00, exp} & m);
  endtask
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, sample_in} = '0;
    {fails, check_count, cycles, stops, clears} = '0;
    reset_n = 1'b0;
    repeat (3) @(posedge core_clk);
    check("analog on in reset", 32'(analog_on), 32'h1);
    reset_n <= 1'b1;
    foreach (rows[i])
    begin
      frame(rows[i].cmd, rows[i].data, rows[i].wcnt, 1'b0);
      if (rows[i].rcnt != 2'h0)
        rdchk("row read", rows[i].rcnt, rows[i].exp);
    end
    $display("test rows done");
    // single shot conversions beyond both full-scale codes, then at minus one
    for (int i = 0; i < 3; i++)
    begin
      sample_in <= smp[i];
      frame(8'h09, 8'h00, 2'h1, 1'b0);
      while (aci_link_if_i.rdy_line !== 1'b0)
        @(posedge core_clk);
      check("one conversion", 32'(conv_busy), 32'h0);
      check("clipped result", 32'(latest_result), 32'(cexp[i]));
      frame(8'h24, 8'h00, 2'h1, 1'b0);
      rdchk("state ready bit", 2'h1, 24'h00_0080);
      frame(8'h1f, 8'h00, 2'h1, 1'b0);
      check("ready released", 32'(aci_link_if_i.rdy_line), 32'h1);
      rdchk("result", 2'h3, cexp[i]);
      frame(8'h27, 8'h00, 2'h1, 1'b0);
      rdchk("state cleared", 2'h1, 24'h00_0000);
      apb(1'b0, HOST_STATUS_OFS, 32'h0);
      check("sticky fall", 32'(q[STAT_FELL_BIT]), 32'h1);
      apb(1'b1, HOST_STATUS_OFS, 32'h0000_0004);
    end
    $display("test conversions done");
    // sleep waits for the running conversion, keeps setup, kick wakes
    frame(8'h08, 8'h00, 2'h1, 1'b0);
    frame(8'h03, 8'h00, 2'h1, 1'b0);
    check("busy at sleep", 32'(conv_busy), 32'h1);
    check("awake at sleep", 32'(analog_on), 32'h1);
    while (analog_on !== 1'b0)
      @(posedge core_clk);
    check("done before sleep", 32'(aci_link_if_i.rdy_line), 32'h0);
    frame(8'h21, 8'h00, 2'h1, 1'b0);
    rdchk("setup kept", 2'h1, 24'h00_00a4);
    frame(8'h08, 8'h00, 2'h1, 1'b0);
    check("woken", 32'(analog_on), 32'h1);
    $display("test sleep done");
    // continuous mode: each kick and setup write clears the filter
    c0 = clears;
    frame(8'h40, 8'h06, 2'h2, 1'b0);
    check("setup clears filter", 32'(clears - c0), 32'h1);
    frame(8'h08, 8'h00, 2'h1, 1'b0);
    check("kick clears filter", 32'(clears - c0), 32'h2);
    frame(8'h1f, 8'h00, 2'h1, 1'b0);
    while (aci_link_if_i.rdy_line !== 1'b0)
      @(posedge core_clk);
    check("still converting", 32'(conv_busy), 32'h1);
    frame(8'h08, 8'h00, 2'h1, 1'b0);
    check("restart clears", 32'(clears - c0), 32'h3);
    $display("test continuous done");
    // reset command restores defaults, link usable at once
    frame(8'h07, 8'h00, 2'h1, 1'b0);
    check("reset ready", 32'(aci_link_if_i.rdy_line), 32'h1);
    check("reset idle", 32'(conv_busy), 32'h0);
    frame(8'h22, 8'h00, 2'h1, 1'b0);
    rdchk("reset setup", 2'h1, 24'h00_0000);
    apb(1'b0, 8'h0c, 32'h0);
    check("unmapped read", q, 32'h0);
    check("no slave error", 32'(pslverr), 32'h0);
    check("no wait state", 32'(pready), 32'h1);
    $display("test reset done");
    test_done();
  end
endmodule
